// ==== dv/tb_fpsv_top.sv ====
// Self-checking bench for the special-value stage: table of single operations, then
// register, sticky flag and reset cases. Drives the ports directly, no partner model.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_fpsv_top;
    import fpsv_pkg::*;
    typedef struct packed {
        logic [2:0] ct;
        fpsv_req_t req;
        logic [63:0] er;
        logic [63:0] ea;
        logic [3:0] ec;
        logic [5:0] ex;
    } fpsv_tb_row_t;
    ////////////////////////////////////////////////////////////////////////////////
    logic sys_clk;
    logic arst_n;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    fpsv_req_t op_req;
    fpsv_rsp_t op_rsp;
    logic mode_ahp;
    logic mode_fz;
    logic mode_dn;
    logic [5:0] flags;
    int fail_count;
    int samples_checked;
    fpsv_tb_row_t rw[$];
    logic [5:0] acc;
    logic [31:0] rd_lo;
    logic [31:0] rd_hi;
    fpsv_top fpsv_top_i (
        .SYS_CLK(sys_clk),
        .ARST_N(arst_n),
        .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr),
        .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata),
        .OP_REQ(op_req),
        .OP_RSP(op_rsp),
        .ALT_HALF_PRECISION_SELECT(mode_ahp),
        .FLUSH_TO_ZERO_ENABLE(mode_fz),
        .DEFAULT_NAN_ENABLE(mode_dn),
        .FP_FLAGS(flags)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Mode md is {fmt, dn, fz, ahp}; ec 4'h8 marks a flushed operand, class not compared
    task automatic add(input logic [4:0] md, input logic [63:0] a, input logic [63:0] b,
        input logic [5:0] fl, input logic [63:0] rs, input logic [63:0] er,
        input logic [3:0] ec, input logic [5:0] ex);
        fpsv_tb_row_t r;
        r = '0;
        r.ct = md[2:0];
        r.req.valid = 1'b1;
        r.req.fmt = fpsv_fmt_t'(md[4:3]);
        r.req.nargs = (b != 64'h0) ? 2'h2 : 2'h1;
        r.req.opa = a;
        r.req.opb = b;
        {r.req.invalid, r.req.recip_div0, r.req.divzero, r.req.overflow, r.req.inexact,
            r.req.res_tiny} = fl;
        r.req.res = rs;
        r.er = er;
        // Flushed operand keeps only its sign bit
        r.ea = !ec[3] ? a : (a & (md[4:3] == 2'h2 ? 64'h8000000000000000 : 64'h80000000));
        r.ec = ec;
        r.ex = ex;
        rw.push_back(r);
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic run_op(input fpsv_req_t r);
        @(posedge sys_clk);
        op_req <= r;
        @(posedge sys_clk);
        op_req.valid <= 1'b0;
        #1;
    endtask
    task automatic reset_pulse();
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK({flags, mode_dn, mode_fz, mode_ahp, op_rsp.valid}, 10'h000)
        @(posedge sys_clk);
        arst_n <= 1'b1;
        // Reset leaves through two flops: third edge is the first usable one
        repeat (3) @(posedge sys_clk);
        reg_read(FPSV_ADDR_CTRL, rd_lo);
        `CHK(rd_lo, {29'h0, FPSV_CTRL_RESET})
        reg_read(FPSV_ADDR_STAT, rd_lo);
        `CHK(rd_lo, {26'h0, FPSV_STAT_RESET})
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        $display("BAD %0t run did not finish", $time);
        complete_run();
    end
    initial begin
        arst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        op_req = '0;
        fail_count = 0;
        samples_checked = 0;
        acc = 6'h00;
        add(5'h08,32'h3F800000,32'h0,6'h00,32'h1,32'h1,4'h2,6'h00);
        add(5'h08,32'h80000001,32'h0,6'h00,32'h0,32'h0,4'h1,6'h00);
        add(5'h08,32'h80000000,32'h0,6'h00,32'h0,32'h0,4'h0,6'h00);
        add(5'h08,32'hFF800000,32'h0,6'h00,32'h0,32'h0,4'h3,6'h00);
        add(5'h08,32'h7FC00001,32'h0,6'h00,32'h1,32'h7FC00001,4'h4,6'h00);
        add(5'h08,32'h7F800001,32'h0,6'h00,32'h0,32'h7FC00001,4'h5,6'h01);
        add(5'h0C,32'h7F800001,32'h0,6'h00,32'h0,FPSV_DNAN_S,4'h5,6'h01);
        add(5'h0C,32'h7FC00001,32'h0,6'h00,32'h0,FPSV_DNAN_S,4'h4,6'h00);
        add(5'h08,32'h3F800000,32'h0,6'h20,32'h0,FPSV_DNAN_S,4'h2,6'h01);
        add(5'h00,16'h3C00,32'h0,6'h20,32'h0,FPSV_DNAN_H,4'h2,6'h01);
        add(5'h00,16'h7C00,32'h0,6'h00,32'h0,32'h0,4'h3,6'h00);
        add(5'h01,16'h7C00,32'h0,6'h00,32'h0,32'h0,4'h2,6'h00);
        add(5'h01,16'h7E01,32'h0,6'h00,32'h0,32'h0,4'h2,6'h00);
        add(5'h09,32'h7F800000,32'h0,6'h00,32'h0,32'h0,4'h3,6'h00);
        add(5'h0A,32'h80000001,32'h0,6'h00,32'h0,32'h0,4'h8,6'h20);
        add(5'h02,16'h8001,32'h0,6'h00,32'h0,32'h0,4'h1,6'h00);
        add(5'h12,64'h1,32'h0,6'h00,32'h0,32'h0,4'h8,6'h20);
        add(5'h0A,32'h0,32'h0,6'h01,32'h80000003,32'h80000000,4'h0,6'h08);
        add(5'h08,32'h0,32'h0,6'h01,32'h3,32'h3,4'h0,6'h08);
        add(5'h0A,32'h0,32'h0,6'h02,32'h3F800001,32'h3F800001,4'h0,6'h10);
        add(5'h08,32'h0,32'h0,6'h10,32'h0,32'h0,4'h0,6'h02);
        add(5'h08,32'h0,32'h0,6'h08,32'h0,32'h0,4'h0,6'h02);
        add(5'h08,32'h0,32'h0,6'h06,32'h7F800000,32'h7F800000,4'h0,6'h14);
        add(5'h08,32'h7FC00002,32'h7F800003,6'h00,32'h0,32'h7FC00003,4'h4,6'h01);
        add(5'h08,32'h7FC00004,32'h7FC00005,6'h00,32'h0,32'h7FC00004,4'h4,6'h00);
        add(5'h0A,32'h1,32'h0,6'h20,32'h0,FPSV_DNAN_S,4'h8,6'h21);
        add(5'h10,64'h1,32'h0,6'h20,32'h0,FPSV_DNAN_D,4'h1,6'h01);
        reset_pulse();
        foreach (rw[i]) begin
            reg_write(FPSV_ADDR_CTRL, {29'h0, rw[i].ct});
            run_op(rw[i].req);
            acc = acc | rw[i].ex;
            `CHK({mode_dn, mode_fz, mode_ahp}, rw[i].ct)
            `CHK(op_rsp.valid, 1'b1)
            `CHK(op_rsp.res, rw[i].er)
            `CHK(op_rsp.opa, rw[i].ea)
            `CHK(op_rsp.exc, rw[i].ex)
            if (!rw[i].ec[3]) begin
                `CHK(op_rsp.cla, fpsv_class_t'(rw[i].ec[2:0]))
            end
        end
        // Sticky flags, status image, last result, unmapped place
        `CHK(flags, acc)
        reg_read(FPSV_ADDR_STAT, rd_lo);
        `CHK(rd_lo, {24'h0, acc[5], 2'h0, acc[4:0]})
        reg_read(FPSV_ADDR_RES_LO, rd_lo);
        reg_read(FPSV_ADDR_RES_HI, rd_hi);
        `CHK({rd_hi, rd_lo}, rw[rw.size() - 1].er)
        reg_write(4'h2, 32'hFFFFFFFF);
        reg_read(4'h2, rd_lo);
        `CHK(rd_lo, 32'h0)
        reg_read(FPSV_ADDR_CTRL, rd_lo);
        `CHK(rd_lo, {29'h0, rw[rw.size() - 1].ct})
        reg_write(FPSV_ADDR_STAT, 32'h80);
        #1;
        `CHK(flags, acc & 6'h1F)
        reg_write(FPSV_ADDR_STAT, 32'h9F);
        #1;
        `CHK(flags, 6'h00)
        // Reset in mid-run with modes and a flag set
        reg_write(FPSV_ADDR_CTRL, 32'h7);
        run_op(rw[8].req);
        `CHK(flags, 6'h01)
        reset_pulse();
        complete_run();
    end
endmodule

// ==== rtl/fpsv_pkg.sv ====
// Shared constants and carriers for the floating-point special-value stage.
// Assumes one clock domain; register port is a plain address/strobe port.
package fpsv_pkg;
    // Register map (byte addresses, one 32-bit word each)
    localparam logic [3:0] FPSV_ADDR_CTRL = 4'h0;
    localparam logic [3:0] FPSV_ADDR_STAT = 4'h4;
    localparam logic [3:0] FPSV_ADDR_RES_LO = 4'h8;
    localparam logic [3:0] FPSV_ADDR_RES_HI = 4'hC;
    // Control field positions
    localparam int FPSV_CTRL_AHP_BIT = 0;
    localparam int FPSV_CTRL_FZ_BIT = 1;
    localparam int FPSV_CTRL_DN_BIT = 2;
    localparam logic [2:0] FPSV_CTRL_RESET = 3'h0;
    // Status field positions (write 1 to clear)
    localparam int FPSV_ST_IOC_BIT = 0;
    localparam int FPSV_ST_DZC_BIT = 1;
    localparam int FPSV_ST_OFC_BIT = 2;
    localparam int FPSV_ST_UFC_BIT = 3;
    localparam int FPSV_ST_IXC_BIT = 4;
    localparam int FPSV_ST_IDC_BIT = 7;
    localparam logic [5:0] FPSV_STAT_RESET = 6'h00;
    // Exponent biases and denormal exponents
    localparam int FPSV_BIAS_H = 15;
    localparam int FPSV_BIAS_S = 127;
    localparam int FPSV_BIAS_D = 1023;
    localparam int FPSV_DEN_EXP_H = -14;
    localparam int FPSV_DEN_EXP_S = -126;
    localparam int FPSV_DEN_EXP_D = -1022;
    localparam int FPSV_AHP_MAX_EXP = 16;
    // Unbiased exponent of the smallest normal magnitude
    localparam int FPSV_SMALLEST_NORMAL_MAGNITUDE_EXP_S = -126;
    localparam int FPSV_SMALLEST_NORMAL_MAGNITUDE_EXP_D = -1022;
    // Default NaN encodings
    localparam logic [15:0] FPSV_DNAN_H = 16'h7E00;
    localparam logic [31:0] FPSV_DNAN_S = 32'h7FC00000;
    localparam logic [63:0] FPSV_DNAN_D = 64'h7FF8000000000000;

    typedef enum logic [1:0] {FPSV_FMT_H = 2'h0, FPSV_FMT_S = 2'h1, FPSV_FMT_D = 2'h2}
        fpsv_fmt_t;
    typedef enum logic [2:0] {
        FPSV_CL_ZERO = 3'h0, FPSV_CL_DENORM = 3'h1, FPSV_CL_NORM = 3'h2,
        FPSV_CL_INF = 3'h3, FPSV_CL_QNAN = 3'h4, FPSV_CL_SNAN = 3'h5
    } fpsv_class_t;

    // Operation request: up to three operands plus raw arithmetic result
    typedef struct packed {
        logic valid;
        fpsv_fmt_t fmt;
        logic [1:0] nargs;
        logic [63:0] opa;
        logic [63:0] opb;
        logic [63:0] opc;
        logic invalid;
        logic recip_div0;
        logic divzero;
        logic overflow;
        logic inexact;
        logic [63:0] res;
        logic res_tiny;
    } fpsv_req_t;

    typedef struct packed {
        logic valid;
        logic [63:0] opa;
        logic [63:0] opb;
        logic [63:0] opc;
        fpsv_class_t cla;
        fpsv_class_t clb;
        fpsv_class_t clc;
        logic [63:0] res;
        logic [5:0] exc;
    } fpsv_rsp_t;

    typedef struct packed {
        logic [2:0] ctrl;
        logic [5:0] stat;
        fpsv_rsp_t rsp;
        logic [31:0] rdata;
    } fpsv_state_t;
endpackage

// ==== rtl/fpsv_top.sv ====
// Special-value stage for a floating-point datapath: classify, flush, NaN select, flags.
// Assumes the arithmetic unit supplies a raw result plus its own exception conditions.
// Operation
// - Zero exponent: nonzero fraction is denormal, else signed zero.
// - All-ones exponent: fraction top bit 0 signaling, 1 quiet NaN, zero infinity.
// - Alternative half format treats all-ones exponent as normal, 2^16 times 1.T.
// - Alt-half select chooses half interpretation; single and double always standard.
// - Normal value uses biases 15, 127, 1023.
// - Denormal value uses exponents -14, -126, -1022.
// - Reciprocal estimates signal divide-by-zero as if dividend were +1.0.
// - Without flush, tininess is judged before rounding.
// - Five IEEE flags plus an input-denormal flag.
// - Flush enable bit turns on flush mode; half values never flushed.
// - Flush mode zeroes single and double denormal inputs.
// - Each flushed input raises the input-denormal flag.
// - No input-denormal flag without flush mode.
// - Input flushing precedes all other exception checks.
// - Flush mode zeroes nonzero tiny results below smallest normal.
// - In flush mode underflow only when a result is flushed.
// - Flushed values keep their sign.
// - Flushing alone never raises inexact.
// - Default-NaN mode returns default NaN for invalid ops and quiet NaN inputs.
// - Otherwise signaling NaN invalid returns first sNaN quieted, else default NaN.
// - Otherwise quiet NaN inputs return the first quiet NaN.
// - Default NaN: sign 0, exponent all ones, only fraction top bit set.
`timescale 1ns/100ps
module fpsv_top
    import fpsv_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // Register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Datapath
    input wire fpsv_pkg::fpsv_req_t OP_REQ,
    output fpsv_pkg::fpsv_rsp_t OP_RSP,
    // Mode and flags
    output logic ALT_HALF_PRECISION_SELECT,
    output logic FLUSH_TO_ZERO_ENABLE,
    output logic DEFAULT_NAN_ENABLE,
    output logic [5:0] FP_FLAGS
);
    import fpsv_pkg::*;

    logic [1:0] rst_sync_r;
    logic rst_n;
    fpsv_state_t st_r, st_nxt;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Format helpers

    function automatic logic [10:0] f_exp(input fpsv_fmt_t f, input logic [63:0] v);
        unique case (f)
            FPSV_FMT_H: f_exp = {6'h00, v[14:10]};
            FPSV_FMT_S: f_exp = {3'h0, v[30:23]};
            default: f_exp = v[62:52];
        endcase
    endfunction

    function automatic logic [51:0] f_frac(input fpsv_fmt_t f, input logic [63:0] v);
        unique case (f)
            FPSV_FMT_H: f_frac = {42'h0, v[9:0]};
            FPSV_FMT_S: f_frac = {29'h0, v[22:0]};
            default: f_frac = v[51:0];
        endcase
    endfunction

    function automatic logic f_sign(input fpsv_fmt_t f, input logic [63:0] v);
        unique case (f)
            FPSV_FMT_H: f_sign = v[15];
            FPSV_FMT_S: f_sign = v[31];
            default: f_sign = v[63];
        endcase
    endfunction

    function automatic logic [10:0] f_emax(input fpsv_fmt_t f);
        unique case (f)
            FPSV_FMT_H: f_emax = 11'h01F;
            FPSV_FMT_S: f_emax = 11'h0FF;
            default: f_emax = 11'h7FF;
        endcase
    endfunction

    // Top fraction bit distinguishes quiet from signaling
    function automatic logic [51:0] f_qbit(input fpsv_fmt_t f);
        unique case (f)
            FPSV_FMT_H: f_qbit = 52'h0000000000200;
            FPSV_FMT_S: f_qbit = 52'h0000000400000;
            default: f_qbit = 52'h8000000000000;
        endcase
    endfunction

    function automatic fpsv_class_t f_class(input fpsv_fmt_t f, input logic [63:0] v,
                                            input logic alt_half_precision_select);
        logic [10:0] e;
        logic [51:0] t;
        e = f_exp(f, v);
        t = f_frac(f, v);
        if (e == 11'h000) begin
            f_class = (t != 52'h0) ? FPSV_CL_DENORM : FPSV_CL_ZERO;
        end else if (e != f_emax(f)) begin
            f_class = FPSV_CL_NORM;
        end else if (f == FPSV_FMT_H && alt_half_precision_select) begin
            f_class = FPSV_CL_NORM;
        end else if (t == 52'h0) begin
            f_class = FPSV_CL_INF;
        end else begin
            f_class = ((t & f_qbit(f)) != 52'h0) ? FPSV_CL_QNAN : FPSV_CL_SNAN;
        end
    endfunction

    // Signed zero of the format; only the sign survives
    function automatic logic [63:0] f_zero(input fpsv_fmt_t f, input logic [63:0] v);
        unique case (f)
            FPSV_FMT_H: f_zero = {48'h0, v[15], 15'h0000};
            FPSV_FMT_S: f_zero = {32'h0, v[31], 31'h00000000};
            default: f_zero = {v[63], 63'h0};
        endcase
    endfunction

    function automatic logic [63:0] f_dnan(input fpsv_fmt_t f);
        unique case (f)
            FPSV_FMT_H: f_dnan = {48'h0, FPSV_DNAN_H};
            FPSV_FMT_S: f_dnan = {32'h0, FPSV_DNAN_S};
            default: f_dnan = FPSV_DNAN_D;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Operand processing

    logic fz, dn, alt_half_precision_select, flushable;
    logic [2:0][63:0] op_in, op_fl;
    fpsv_class_t [2:0] cl_raw, cl_fl;
    logic [2:0] in_flush;

    assign alt_half_precision_select = st_r.ctrl[FPSV_CTRL_AHP_BIT];
    assign fz = st_r.ctrl[FPSV_CTRL_FZ_BIT];
    assign dn = st_r.ctrl[FPSV_CTRL_DN_BIT];
    assign flushable = fz && (OP_REQ.fmt != FPSV_FMT_H);
    assign op_in = {OP_REQ.opc, OP_REQ.opb, OP_REQ.opa};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_op
            logic used;
            assign used = (OP_REQ.nargs > 2'(gi));
            assign cl_raw[gi] = f_class(OP_REQ.fmt, op_in[gi], alt_half_precision_select);
            // Flushing first, so later checks see the flushed operand
            assign in_flush[gi] = used && flushable && (cl_raw[gi] == FPSV_CL_DENORM);
            assign op_fl[gi] = in_flush[gi] ? f_zero(OP_REQ.fmt, op_in[gi]) : op_in[gi];
            assign cl_fl[gi] = !used ? FPSV_CL_ZERO :
                               (in_flush[gi] ? FPSV_CL_ZERO : cl_raw[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // NaN selection and result flush

    logic any_snan, any_qnan, invalid, res_flush, uf;
    logic [63:0] first_snan, first_qnan, res_out;
    logic [5:0] exc;

    always_comb begin
        any_snan = 1'b0;
        any_qnan = 1'b0;
        first_snan = 64'h0;
        first_qnan = 64'h0;
        // Walk from the last argument so the leftmost one wins
        for (int i = 2; i >= 0; i--) begin
            if (cl_fl[i] == FPSV_CL_SNAN) begin
                any_snan = 1'b1;
                first_snan = op_fl[i] | {12'h0, f_qbit(OP_REQ.fmt)};
            end
            if (cl_fl[i] == FPSV_CL_QNAN) begin
                any_qnan = 1'b1;
                first_qnan = op_fl[i];
            end
        end
        invalid = OP_REQ.invalid || any_snan;
        // Tininess uses the unrounded magnitude from the datapath
        res_flush = flushable && OP_REQ.res_tiny;
        uf = fz ? res_flush : OP_REQ.res_tiny;
        if (invalid) begin
            res_out = (dn || !any_snan) ? f_dnan(OP_REQ.fmt) : first_snan;
        end else if (any_qnan) begin
            res_out = dn ? f_dnan(OP_REQ.fmt) : first_qnan;
        end else if (res_flush) begin
            res_out = f_zero(OP_REQ.fmt, OP_REQ.res);
        end else begin
            res_out = OP_REQ.res;
        end
        exc = 6'h00;
        exc[FPSV_ST_IOC_BIT] = invalid;
        exc[FPSV_ST_DZC_BIT] = !invalid && (OP_REQ.divzero || OP_REQ.recip_div0);
        exc[FPSV_ST_OFC_BIT] = !invalid && OP_REQ.overflow;
        exc[FPSV_ST_UFC_BIT] = !invalid && uf;
        // A flushed result is exact by definition here
        exc[FPSV_ST_IXC_BIT] = !invalid && OP_REQ.inexact && !res_flush;
        exc[5] = |in_flush;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State update

    logic [5:0] clr;
    always_comb begin
        st_nxt = st_r;
        clr = 6'h00;
        st_nxt.rsp.valid = OP_REQ.valid;
        if (OP_REQ.valid) begin
            st_nxt.rsp.opa = op_fl[0];
            st_nxt.rsp.opb = op_fl[1];
            st_nxt.rsp.opc = op_fl[2];
            st_nxt.rsp.cla = cl_fl[0];
            st_nxt.rsp.clb = cl_fl[1];
            st_nxt.rsp.clc = cl_fl[2];
            st_nxt.rsp.res = res_out;
            st_nxt.rsp.exc = exc;
        end
        if (REG_WR && REG_ADDR == FPSV_ADDR_CTRL) begin
            st_nxt.ctrl = REG_WDATA[2:0];
        end
        if (REG_WR && REG_ADDR == FPSV_ADDR_STAT) begin
            clr = {REG_WDATA[FPSV_ST_IDC_BIT], REG_WDATA[4:0]};
        end
        // Set beats clear in the same cycle
        st_nxt.stat = (st_r.stat & ~clr) | (OP_REQ.valid ? exc : 6'h00);
        st_nxt.rdata = 32'h0;
        if (REG_RD) begin
            unique case (REG_ADDR)
                FPSV_ADDR_CTRL: st_nxt.rdata = {29'h0, st_r.ctrl};
                FPSV_ADDR_STAT: st_nxt.rdata = {24'h0, st_r.stat[5], 2'h0, st_r.stat[4:0]};
                FPSV_ADDR_RES_LO: st_nxt.rdata = st_r.rsp.res[31:0];
                FPSV_ADDR_RES_HI: st_nxt.rdata = st_r.rsp.res[63:32];
                default: st_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign REG_RDATA = st_r.rdata;
    assign OP_RSP = st_r.rsp;
    assign ALT_HALF_PRECISION_SELECT = alt_half_precision_select;
    assign FLUSH_TO_ZERO_ENABLE = fz;
    assign DEFAULT_NAN_ENABLE = dn;
    assign FP_FLAGS = st_r.stat;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_idc_needs_fz;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && !fz |=> !OP_RSP.exc[5];
    endproperty
    a_idc_needs_fz: assert property (p_idc_needs_fz) else $error("denormal flag without flush");

    property p_half_not_flushed;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && OP_REQ.fmt == FPSV_FMT_H |=> !OP_RSP.exc[5];
    endproperty
    a_half_not_flushed: assert property (p_half_not_flushed) else $error("half value flushed");

    property p_flush_denorm;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && fz && OP_REQ.fmt == FPSV_FMT_S && OP_REQ.nargs != 2'h0 &&
            OP_REQ.opa[30:23] == 8'h00 && OP_REQ.opa[22:0] != 23'h0
        |=> OP_RSP.opa[30:0] == 31'h0 && OP_RSP.exc[5] && OP_RSP.opa[31] == $past(OP_REQ.opa[31]);
    endproperty
    a_flush_denorm: assert property (p_flush_denorm) else $error("denormal input not flushed");

    property p_uf_fz;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && fz && !invalid |=> OP_RSP.exc[3] == $past(res_flush);
    endproperty
    a_uf_fz: assert property (p_uf_fz) else $error("underflow not tied to flush");

    property p_no_ixc_flush;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && res_flush |=> !OP_RSP.exc[4];
    endproperty
    a_no_ixc_flush: assert property (p_no_ixc_flush) else $error("inexact on flush");

    property p_dn_result;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && dn && OP_REQ.fmt == FPSV_FMT_S && (invalid || any_qnan)
        |=> OP_RSP.res[31:0] == FPSV_DNAN_S;
    endproperty
    a_dn_result: assert property (p_dn_result) else $error("default NaN missing");

    property p_snan_quieted;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && !dn && OP_REQ.fmt == FPSV_FMT_S && OP_REQ.nargs != 2'h0 &&
            cl_fl[0] == FPSV_CL_SNAN
        |=> OP_RSP.res[31:0] == ($past(OP_REQ.opa[31:0]) | 32'h00400000) && OP_RSP.exc[0];
    endproperty
    a_snan_quieted: assert property (p_snan_quieted) else $error("sNaN not propagated");

    property p_qnan_first;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && !dn && !invalid && cl_fl[0] == FPSV_CL_QNAN
        |=> OP_RSP.res == $past(OP_REQ.opa);
    endproperty
    a_qnan_first: assert property (p_qnan_first) else $error("first qNaN not returned");

    property p_flag_sticky;
        @(posedge SYS_CLK) disable iff (!rst_n)
        FP_FLAGS[0] && !(REG_WR && REG_ADDR == FPSV_ADDR_STAT) |=> FP_FLAGS[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_rsp_follows_req;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid |=> OP_RSP.valid;
    endproperty
    a_rsp_follows_req: assert property (p_rsp_follows_req) else $error("no response");

    property p_idc_on_flush;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && (|in_flush) |=> OP_RSP.exc[5];
    endproperty
    a_idc_on_flush: assert property (p_idc_on_flush) else $error("flush without flag");

    property p_zero_class;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && OP_REQ.fmt == FPSV_FMT_S && OP_REQ.nargs != 2'h0 &&
            OP_REQ.opa[30:0] == 31'h0
        |=> OP_RSP.cla == FPSV_CL_ZERO;
    endproperty
    a_zero_class: assert property (p_zero_class) else $error("zero misclassified");

    property p_inf_class;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && OP_REQ.fmt == FPSV_FMT_S && OP_REQ.nargs != 2'h0 &&
            OP_REQ.opa[30:0] == 31'h7F800000
        |=> OP_RSP.cla == FPSV_CL_INF;
    endproperty
    a_inf_class: assert property (p_inf_class) else $error("infinity misclassified");

    property p_ahp_norm;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && alt_half_precision_select && OP_REQ.fmt == FPSV_FMT_H && OP_REQ.nargs != 2'h0 &&
            OP_REQ.opa[14:10] == 5'h1F
        |=> OP_RSP.cla == FPSV_CL_NORM;
    endproperty
    a_ahp_norm: assert property (p_ahp_norm) else $error("alt half not normal");

    property p_dnan_half;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && OP_REQ.fmt == FPSV_FMT_H && invalid && (dn || !any_snan)
        |=> OP_RSP.res[15:0] == FPSV_DNAN_H;
    endproperty
    a_dnan_half: assert property (p_dnan_half) else $error("half default NaN wrong");

    property p_dnan_double;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && OP_REQ.fmt == FPSV_FMT_D && invalid && (dn || !any_snan)
        |=> OP_RSP.res == FPSV_DNAN_D;
    endproperty
    a_dnan_double: assert property (p_dnan_double) else $error("double default NaN wrong");

    // Result flush must leave only the sign of the raw result
    property p_res_flush_sign;
        @(posedge SYS_CLK) disable iff (!rst_n)
        OP_REQ.valid && res_flush && !invalid && !any_qnan && OP_REQ.fmt == FPSV_FMT_S
        |=> OP_RSP.res[31:0] == {$past(OP_REQ.res[31]), 31'h0};
    endproperty
    a_res_flush_sign: assert property (p_res_flush_sign) else $error("result not flushed");
endmodule
